//--- rtl/smpa_cfg.svh
// Constants for the protected serial memory access block
`ifndef SMPA_CFG_SVH
`define SMPA_CFG_SVH

// ----------------------------------------------------------------------
// Array geometry
// ----------------------------------------------------------------------
`define SMPA_ADDR_W         11
`define SMPA_DATA_W         8
`define SMPA_ADDR_LAST      11'h7FF

// ----------------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------------
`define SMPA_OP_SET_WE      8'h06
`define SMPA_OP_CLR_WE      8'h04
`define SMPA_OP_RD_STAT     8'h05
`define SMPA_OP_WR_STAT     8'h01
`define SMPA_OP_READ        8'h03
`define SMPA_OP_WRITE       8'h02

// ----------------------------------------------------------------------
// Status register layout and reset value
// ----------------------------------------------------------------------
`define SMPA_ST_PEN_BIT     7
`define SMPA_ST_BPHI_BIT    3
`define SMPA_ST_BPLO_BIT    2
`define SMPA_ST_WEL_BIT     1
`define SMPA_ST_RESET       8'h00

// ----------------------------------------------------------------------
// Block protect ranges
// ----------------------------------------------------------------------
`define SMPA_PROT_QTR_BASE  11'h600
`define SMPA_PROT_HALF_BASE 11'h400

// ----------------------------------------------------------------------
// Field lengths in serial clocks, counted from zero
// ----------------------------------------------------------------------
`define SMPA_BYTE_LAST      4'h7
`define SMPA_ADDR_FLD_LAST  4'hF

`endif

//--- rtl/smpa_pkg.sv
// Types shared by the protected serial memory access block
`default_nettype none
package smpa_pkg;
  `include "smpa_cfg.svh"

  typedef logic [`SMPA_ADDR_W-1:0] smpa_addr_t;
  typedef logic [`SMPA_DATA_W-1:0] smpa_byte_t;

  // Frame phases of the serial link
  typedef enum logic [2:0] {
    ST_OPCODE = 3'b000,
    ST_ADDR   = 3'b001,
    ST_WSTAT  = 3'b010,
    ST_RSTAT  = 3'b011,
    ST_WDATA  = 3'b100,
    ST_RDATA  = 3'b101,
    ST_IGNORE = 3'b110
  } smpa_state_e;
endpackage
`default_nettype wire

//--- rtl/smpa_sync.sv
// Two-flop level synchroniser, one lane per bit
`timescale 1ns/1ns
`default_nettype none
module smpa_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,   // Destination clock
  input  wire logic [WIDTH-1:0] din,   // Level from the other domain
  output logic      [WIDTH-1:0] dout   // Synchronised level
);
  logic [WIDTH-1:0] stage1;

  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    stage1 <= din;
    dout   <= stage1;
  end
endmodule
`default_nettype wire

//--- rtl/smpa_mem.sv
// Byte array with combinational read and clocked write
`timescale 1ns/1ns
`default_nettype none
module smpa_mem #(
  parameter int ADDR_W = 11,
  parameter int DATA_W = 8
) (
  input  wire logic              clk,     // Write clock
  input  wire logic              set_write_enable,    // Commit one byte
  input  wire logic [ADDR_W-1:0] wrAddr,  // Write address
  input  wire logic [DATA_W-1:0] wrData,  // Write data
  input  wire logic [ADDR_W-1:0] rdAddr,  // Read address
  output logic      [DATA_W-1:0] rdData   // Read data
);
  logic [DATA_W-1:0] cells [0:(1<<ADDR_W)-1];

  // Nonvolatile contents: no reset touches the cells
  always_ff @(posedge clk) begin
    if (set_write_enable) begin
      cells[wrAddr] <= wrData;
    end
  end

  // Read must be ready within the same serial edge
  assign rdData = cells[rdAddr];
endmodule
`default_nettype wire

//--- rtl/smpa_top.sv
// Serial memory slave with status register and write protection
//
// Notes on behaviour
// RULE1: Status bits 0, 4, 5, 6 cannot be written and read as zero.
// RULE2: Status layout: pin enable 7, protect hi 3, protect lo 2, latch 1.
// RULE3: Status bits start at zero; the write enable latch clears on reset.
// RULE4: Status write never sets the latch; only the set latch command does.
// RULE5: Block protect bits are kept like nonvolatile cells, never reset.
// RULE6: Protect code 00 none, 01 600h-7FFh, 10 400h-7FFh, 11 all.
// RULE7: Pin enable set and protect pin low blocks status writes.
// RULE8: The protect pin never blocks array writes.
// RULE9: Array write needs the latch set and an unprotected address.
// RULE10: Status read opcode shifts out the status byte.
// RULE11: Status write needs the latch first and then clears the latch.
// RULE12: Master holds the protect pin high before a status write.
// RULE13: Write opcode, two address bytes, low 11 bits used.
// RULE14: Burst address increments per byte and wraps 7FFh to 000h.
// RULE15: Each write byte commits on its eighth clock, no page buffer.
// RULE16: Burst write reaching a protected address stops and drops data.
// RULE17: Data is MSB first; chip select rising ends the write.
// RULE18: Read drives data MSB first after address, input ignored.
// RULE19: Chip select rising ends a read and floats the output.
// RULE20: Pause pin low pauses the frame, high resumes it.
// RULE21: Master changes the pause pin only while serial clock is low.
// RULE22: Opcodes: set latch 06h, clear latch 04h, status read 05h.
// RULE23: Opcodes: status write 01h, read 03h, write 02h; others ignored.
// RULE24: Latch clears at chip select rise after clear, status or write.
// RULE25: Input sampled on rising clock, output changed on falling clock.
// RULE26: Status write applies after eight data bits; later bytes ignored.
`timescale 1ns/1ns
`default_nettype none
`include "smpa_cfg.svh"
module smpa_top
  import smpa_pkg::*;
#(
  parameter int ADDR_W = `SMPA_ADDR_W,
  parameter int DATA_W = `SMPA_DATA_W
) (
  input  wire logic sys_clk,          // System clock, 50 MHz
  input  wire logic rst_n,            // Synchronous reset, active low
  input  wire logic spiClk,           // Serial clock from the master
  input  wire logic chipSel_n,        // Chip select, active low
  input  wire logic serIn,            // Serial data in
  output logic      serOut,           // Serial data out
  output logic      serOutOe_n,       // Output enable, low drives pin
  input  wire logic writeProtect_n,   // Status protect pin, active low
  input  wire logic pause_n,          // Pause pin, active low
  output logic      writeEnableLatch, // Latch state, system domain
  output logic      protectPinEnable, // Pin enable bit, synchronised
  output logic      blockProtectHi,   // Protect hi bit, synchronised
  output logic      blockProtectLo,   // Protect lo bit, synchronised
  output logic      frameActive       // Chip select low, synchronised
);
  import smpa_pkg::*;

  // --------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------
  smpa_state_e state;
  smpa_state_e next_state;
  logic [3:0]  bitPos;
  logic [15:0] rxShift;
  logic [15:0] rxWord;
  logic [7:0]  rxByte;
  logic        fieldDone;
  logic        opIsRead;
  smpa_addr_t  addr;
  smpa_addr_t  memRdAddr;
  smpa_byte_t  memRdData;
  smpa_byte_t  txByte;
  logic        burstStopped;
  logic        memWrEn;
  logic        wrBlocked;
  logic        statWrAllowed;
  logic        driving;
  logic        setTgl = 1'b0;
  logic        clrTgl = 1'b0;
  logic        stPen  = 1'b0;
  logic        stBpHi = 1'b0;
  logic        stBpLo = 1'b0;
  logic [7:0]  statusByte;
  logic        welLink;
  logic        wpLink_n;
  logic        setSync;
  logic        clrSync;
  logic        csSync;
  logic        setSeen;
  logic        clrSeen;
  logic        clrPend;
  logic [2:0]  stSync;

  // --------------------------------------------------------------------
  // Protect range decode
  // --------------------------------------------------------------------
  // Whole-array code covers everything, quarter and half cover the top
  function automatic logic addrProtected(input smpa_addr_t a,
                                         input logic hi,
                                         input logic lo);
    logic prot;
    prot = 1'b0;
    unique case ({hi, lo})
      2'b00: prot = 1'b0;                           // RULE6
      2'b01: prot = (a >= `SMPA_PROT_QTR_BASE);     // RULE6
      2'b10: prot = (a >= `SMPA_PROT_HALF_BASE);    // RULE6
      2'b11: prot = 1'b1;                           // RULE6
    endcase
    return prot;
  endfunction

  // --------------------------------------------------------------------
  // Link side: bit capture and frame sequencing
  // --------------------------------------------------------------------
  // Latest bit joins the shift history; MSB arrives first
  assign rxWord = {rxShift[14:0], serIn};  // RULE17
  assign rxByte = rxWord[7:0];

  // Address field is sixteen clocks, all others eight
  assign fieldDone = (state == ST_ADDR) ? (bitPos == `SMPA_ADDR_FLD_LAST)
                                        : (bitPos == `SMPA_BYTE_LAST);

  // Next phase once a field completes
  always_comb begin
    next_state = state;
    unique case (state)
      ST_OPCODE: begin
        unique case (rxByte)
          `SMPA_OP_RD_STAT: next_state = ST_RSTAT;  // RULE10
          `SMPA_OP_WR_STAT: next_state = ST_WSTAT;  // RULE23
          `SMPA_OP_READ:    next_state = ST_ADDR;   // RULE23
          `SMPA_OP_WRITE:   next_state = ST_ADDR;   // RULE13
          default:          next_state = ST_IGNORE; // RULE23
        endcase
      end
      ST_ADDR:   next_state = opIsRead ? ST_RDATA : ST_WDATA;
      ST_WSTAT:  next_state = ST_IGNORE;             // RULE26
      ST_RSTAT:  next_state = ST_RSTAT;
      ST_WDATA:  next_state = ST_WDATA;
      ST_RDATA:  next_state = ST_RDATA;
      ST_IGNORE: next_state = ST_IGNORE;
      default:   next_state = ST_IGNORE;
    endcase
  end

  // Chip select high clears the frame; a paused clock edge is dropped
  always_ff @(posedge spiClk or posedge chipSel_n) begin
    if (chipSel_n) begin
      state   <= ST_OPCODE;
      bitPos  <= 4'h0;
      rxShift <= 16'h0000;
    end else if (pause_n) begin                      // RULE20
      rxShift <= rxWord;                             // RULE25
      bitPos  <= fieldDone ? 4'h0 : bitPos + 4'h1;
      if (fieldDone) begin
        state <= next_state;
      end
    end
  end

  // Direction of a memory access, caught with the opcode
  always_ff @(posedge spiClk or posedge chipSel_n) begin
    if (chipSel_n) begin
      opIsRead <= 1'b0;
    end else if (pause_n && fieldDone && state == ST_OPCODE) begin
      opIsRead <= (rxByte == `SMPA_OP_READ);
    end
  end

  // --------------------------------------------------------------------
  // Link side: address counter and array access
  // --------------------------------------------------------------------
  // The first read byte is fetched from the address still in flight
  assign memRdAddr = (state == ST_ADDR) ? rxWord[ADDR_W-1:0] : addr;

  // Latch clear protects everything; the protect pin plays no part here
  assign wrBlocked = !welLink                                 // RULE9
                   || addrProtected(addr, stBpHi, stBpLo);    // RULE8

  // Byte commits on its eighth clock straight into the array
  assign memWrEn = pause_n && !chipSel_n && fieldDone
                 && state == ST_WDATA && !burstStopped
                 && !wrBlocked;                               // RULE15

  // Upper five address bits are dropped; counter wraps by its width
  always_ff @(posedge spiClk or posedge chipSel_n) begin
    if (chipSel_n) begin
      addr         <= '0;
      burstStopped <= 1'b0;
    end else if (pause_n && fieldDone) begin
      if (state == ST_ADDR) begin
        addr <= opIsRead ? rxWord[ADDR_W-1:0] + 1'b1         // RULE14
                         : rxWord[ADDR_W-1:0];               // RULE13
      end else if (state == ST_RDATA) begin
        addr <= addr + 1'b1;                                 // RULE14
      end else if (state == ST_WDATA && !burstStopped) begin
        if (wrBlocked) begin
          burstStopped <= 1'b1;                              // RULE16
        end else begin
          addr <= addr + 1'b1;                               // RULE14
        end
      end
    end
  end

  smpa_mem #(
    .ADDR_W (ADDR_W),
    .DATA_W (DATA_W)
  ) u_mem (
    .clk    (spiClk),
    .set_write_enable   (memWrEn),
    .wrAddr (addr),
    .wrData (rxByte),
    .rdAddr (memRdAddr),
    .rdData (memRdData)
  );

  // --------------------------------------------------------------------
  // Link side: status register
  // --------------------------------------------------------------------
  // Unused bits are tied low, the latch is shown from its own flop
  always_comb begin
    statusByte = `SMPA_ST_RESET;                               // RULE1
    statusByte[`SMPA_ST_PEN_BIT]  = stPen;                     // RULE2
    statusByte[`SMPA_ST_BPHI_BIT] = stBpHi;                    // RULE2
    statusByte[`SMPA_ST_BPLO_BIT] = stBpLo;                    // RULE2
    statusByte[`SMPA_ST_WEL_BIT]  = welLink;                   // RULE2
  end

  // Pin counts only with its enable bit set
  assign statWrAllowed = welLink                               // RULE11
                       && !(stPen && !wpLink_n);               // RULE7

  // Protect bits carry no reset so they survive like nonvolatile cells;
  // the latch bit in the written byte is never looked at
  always_ff @(posedge spiClk) begin
    if (pause_n && !chipSel_n && fieldDone && state == ST_WSTAT
        && statWrAllowed) begin                                // RULE26
      stPen  <= rxByte[`SMPA_ST_PEN_BIT];                      // RULE11
      stBpHi <= rxByte[`SMPA_ST_BPHI_BIT];                     // RULE5
      stBpLo <= rxByte[`SMPA_ST_BPLO_BIT];                     // RULE5
    end
  end

  // Latch events leave the link as toggles, free of frame reset
  always_ff @(posedge spiClk) begin
    if (pause_n && !chipSel_n && fieldDone && state == ST_OPCODE) begin
      if (rxByte == `SMPA_OP_SET_WE) begin                     // RULE22
        setTgl <= !setTgl;                                     // RULE4
      end
      if (rxByte == `SMPA_OP_CLR_WE || rxByte == `SMPA_OP_WR_STAT
          || rxByte == `SMPA_OP_WRITE) begin
        clrTgl <= !clrTgl;                                     // RULE24
      end
    end
  end

  // --------------------------------------------------------------------
  // Link side: serial output
  // --------------------------------------------------------------------
  // Byte to send is loaded on the edge that completes the previous field
  always_ff @(posedge spiClk or posedge chipSel_n) begin
    if (chipSel_n) begin
      txByte <= 8'h00;
    end else if (pause_n && fieldDone) begin
      if (state == ST_OPCODE || state == ST_RSTAT) begin
        txByte <= statusByte;                                  // RULE10
      end else if (state == ST_ADDR || state == ST_RDATA) begin
        txByte <= memRdData;                                   // RULE18
      end
    end
  end

  // Output moves on the falling edge, MSB first
  always_ff @(negedge spiClk or posedge chipSel_n) begin
    if (chipSel_n) begin
      serOut <= 1'b0;
    end else if (pause_n) begin                                // RULE20
      serOut <= txByte[3'd7 - bitPos[2:0]];                    // RULE25
    end
  end

  // Only read phases drive; a pause or frame end floats the pin
  assign driving    = (state == ST_RSTAT) || (state == ST_RDATA);
  assign serOutOe_n = !(driving && !chipSel_n && pause_n);     // RULE19

  // Latch and pin enter the link clock; both settle long before use
  smpa_sync #(
    .WIDTH (2)
  ) u_linkSync (
    .clk  (spiClk),
    .din  ({writeEnableLatch, writeProtect_n}),
    .dout ({welLink, wpLink_n})
  );

  // --------------------------------------------------------------------
  // System side: write enable latch
  // --------------------------------------------------------------------
  smpa_sync #(
    .WIDTH (3)
  ) u_sysSync (
    .clk  (sys_clk),
    .din  ({setTgl, clrTgl, chipSel_n}),
    .dout ({setSync, clrSync, csSync})
  );

  // Toggle history follows the synchroniser even in reset
  always_ff @(posedge sys_clk) begin
    setSeen <= setSync;
    clrSeen <= clrSync;
  end

  // A clear waits for the end of its frame
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      clrPend <= 1'b0;
    end else if (clrSync != clrSeen) begin
      clrPend <= 1'b1;
    end else if (csSync) begin
      clrPend <= 1'b0;                                         // RULE24
    end
  end

  // Set wins over a clear landing in the same cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      writeEnableLatch <= 1'b0;                                // RULE3
    end else if (setSync != setSeen) begin
      writeEnableLatch <= 1'b1;                                // RULE4
    end else if (clrPend && csSync) begin
      writeEnableLatch <= 1'b0;                                // RULE24
    end
  end

  // --------------------------------------------------------------------
  // System side: status view
  // --------------------------------------------------------------------
  // Bits change only mid-frame, so a brief skew between them is harmless
  smpa_sync #(
    .WIDTH (3)
  ) u_statSync (
    .clk  (sys_clk),
    .din  ({stPen, stBpHi, stBpLo}),
    .dout (stSync)
  );

  // Registered copies for the system, cleared by reset
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      protectPinEnable <= 1'b0;
      blockProtectHi   <= 1'b0;
      blockProtectLo   <= 1'b0;
      frameActive      <= 1'b0;
    end else begin
      protectPinEnable <= stSync[2];
      blockProtectHi   <= stSync[1];
      blockProtectLo   <= stSync[0];
      frameActive      <= !csSync;
    end
  end
endmodule
`default_nettype wire

//--- test/smpa_asserts.sv
// Port-level checks on the protected serial memory block
`timescale 1ns/1ns
`default_nettype none
module smpa_asserts (
  input wire logic sys_clk,          // System clock
  input wire logic rst_n,            // Synchronous reset
  input wire logic chipSel_n,        // Chip select
  input wire logic pause_n,          // Pause pin
  input wire logic serOut,           // Serial data out
  input wire logic serOutOe_n,       // Output enable
  input wire logic writeEnableLatch, // Latch view
  input wire logic protectPinEnable, // Pin enable view
  input wire logic blockProtectHi,   // Protect hi view
  input wire logic blockProtectLo,   // Protect lo view
  input wire logic frameActive       // Frame view
);
  // ----------------------------------------------------------------
  // Checks in the system clock domain
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // Frame view trails chip select by the synchroniser depth
  sequence s_up;
    ##[1:5] frameActive;
  endsequence
  sequence s_down;
    ##[1:5] !frameActive;
  endsequence

  // Output pin floats whenever the frame is closed or paused
  a_oe_idle: assert property (chipSel_n |-> serOutOe_n)
    else $error("Output driven while deselected");
  a_out_idle: assert property (chipSel_n |-> !serOut)
    else $error("Output not at rest while deselected");
  a_oe_pause: assert property (!pause_n |-> serOutOe_n)
    else $error("Output driven while paused");
  a_frame_up: assert property ($fell(chipSel_n) |-> s_up)
    else $error("Frame view missed chip select fall");
  a_frame_down: assert property ($rose(chipSel_n) |-> s_down)
    else $error("Frame view missed chip select rise");
  // Latch only sets inside a frame and only clears once it is closed
  a_latch_set: assert property ($rose(writeEnableLatch) |-> frameActive)
    else $error("Latch set outside a frame");
  a_latch_clr: assert property ($fell(writeEnableLatch) |-> chipSel_n)
    else $error("Latch cleared inside a frame");
  a_reset_clr: assert property ($rose(rst_n) |->
    !writeEnableLatch && !frameActive)
    else $error("Latch or frame view set after reset");
  a_view_reset: assert property ($rose(rst_n) |->
    !protectPinEnable && !blockProtectHi && !blockProtectLo)
    else $error("Status view not clear after reset");
endmodule

bind smpa_top smpa_asserts u_chk (.sys_clk, .rst_n, .chipSel_n, .pause_n,
  .serOut, .serOutOe_n, .writeEnableLatch, .protectPinEnable,
  .blockProtectHi, .blockProtectLo, .frameActive);
`default_nettype wire

//--- test/smpa_master.sv
// Serial bus master model driving the memory slave pins
`timescale 1ns/1ns
`default_nettype none
module smpa_master (
  output logic      spiClk,         // Serial clock, rests low
  output logic      chipSel_n,      // Chip select
  output logic      serIn,          // Data to the slave
  output logic      pause_n,        // Pause pin
  output logic      writeProtect_n, // Status protect pin
  input  wire logic soLine          // Resolved slave output
);
  import smpa_pkg::*;
  // ----------------------------------------------------------------
  // Frame and byte tasks, 32 ns link clock
  // ----------------------------------------------------------------
  localparam int HalfNs = 16;

  // Idle pins; clock stands still outside frames
  initial begin
    spiClk = 1'b0;
    chipSel_n = 1'b0;
    serIn = 1'b0;
    pause_n = 1'b1;
    writeProtect_n = 1'b1;
    // A real rising edge clears the frame logic before any use
    #1 chipSel_n = 1'b1;
  end

  task automatic csLow();
    #7 chipSel_n = 1'b0;
    #HalfNs;
  endtask

  // Late rise keeps the latch update inside the frame; the long gap
  // gives the clear time to cross into the system domain
  task automatic csHigh();
    #(3 * HalfNs) chipSel_n = 1'b1;
    serIn = ~serIn;
    #200;
  endtask

  // One byte each way, MSB first, optional pause before bit pb
  task automatic xb(input smpa_byte_t o, output smpa_byte_t i,
                    input int pb = -1);
    for (int b = 7; b >= 0; b--) begin
      if (b == pb) hold();
      serIn = o[b];
      #HalfNs i[b] = soLine;
      spiClk = 1'b1;
      #HalfNs spiClk = 1'b0;
    end
  endtask

  // Pause pin moves only with the clock low; the clock keeps running
  task automatic hold();
    #4 pause_n = 1'b0;
    repeat (3) begin
      #HalfNs spiClk = 1'b1;
      serIn = ~serIn;
      #HalfNs spiClk = 1'b0;
    end
    #4 pause_n = 1'b1;
  endtask
endmodule
`default_nettype wire

//--- test/spi_memory_protect_access_tb_top.sv
// Self-checking bench for the protected serial memory block
`timescale 1ns/1ns
`default_nettype none
`include "smpa_cfg.svh"
module spi_memory_protect_access_tb_top;
  import smpa_pkg::*;
  // ----------------------------------------------------------------
  // Signals, design and master model
  // ----------------------------------------------------------------
  logic       sys_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       spiClk, chipSel_n, serIn, pause_n, writeProtect_n;
  logic       serOut, serOutOe_n, writeEnableLatch, frameActive;
  logic       protectPinEnable, blockProtectHi, blockProtectLo;
  wire        soLine;
  int         n_fail = 0;
  int         num_checks = 0;
  int         cyc = 0;
  smpa_byte_t d, s, r0, r1;

  // Floating output reads as z so a missing drive never matches
  assign soLine = serOutOe_n ? 1'bz : serOut;

  smpa_top DUT (.sys_clk(sys_clk), .rst_n(rst_n), .spiClk(spiClk),
    .chipSel_n(chipSel_n), .serIn(serIn), .serOut(serOut),
    .serOutOe_n(serOutOe_n), .writeProtect_n(writeProtect_n),
    .pause_n(pause_n), .writeEnableLatch(writeEnableLatch),
    .protectPinEnable(protectPinEnable), .blockProtectHi(blockProtectHi),
    .blockProtectLo(blockProtectLo), .frameActive(frameActive));
  smpa_master M (.spiClk(spiClk), .chipSel_n(chipSel_n), .serIn(serIn),
    .pause_n(pause_n), .writeProtect_n(writeProtect_n), .soLine(soLine));

  initial begin
    forever #10 sys_clk = ~sys_clk;
  end

  // Hang guard, far above the few thousand cycles the run needs
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_fail++;
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic test_done();
    if (n_fail == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmd(input smpa_byte_t op);
    M.csLow();
    M.xb(op, d);
    M.csHigh();
  endtask

  task automatic read_status_cmd(input smpa_byte_t exp);
    M.csLow();
    M.xb(`SMPA_OP_RD_STAT, d);
    chk(frameActive, 1'b1);
    M.xb(8'h5A, s);
    M.csHigh();
    chk(s, exp);
  endtask

  // Trailing byte must be ignored by the status write
  task automatic write_status_cmd(input smpa_byte_t v);
    cmd(`SMPA_OP_SET_WE);
    M.csLow();
    M.xb(`SMPA_OP_WR_STAT, d);
    M.xb(v, d);
    M.xb(~v, d);
    M.csHigh();
  endtask

  task automatic wr(input logic [15:0] a, input smpa_byte_t v0, v1,
                    input bit en);
    if (en) cmd(`SMPA_OP_SET_WE);
    M.csLow();
    M.xb(`SMPA_OP_WRITE, d);
    M.xb(a[15:8], d);
    M.xb(a[7:0], d);
    M.xb(v0, d);
    M.xb(v1, d);
    M.csHigh();
  endtask

  // Input carries the complement during data to prove it is ignored
  task automatic rd(input logic [15:0] a, input smpa_byte_t e0, e1,
                    input int pb);
    M.csLow();
    M.xb(`SMPA_OP_READ, d);
    M.xb(a[15:8], d);
    M.xb(a[7:0], d);
    M.xb(~e0, r0, pb);
    M.xb(~e1, r1);
    M.csHigh();
    chk(r0, e0);
    chk(r1, e1);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_latch();
    chk(writeEnableLatch, 1'b0);
    read_status_cmd(8'h00);
    cmd(`SMPA_OP_SET_WE);
    chk(writeEnableLatch, 1'b1);
    read_status_cmd(8'h02);
    cmd(`SMPA_OP_CLR_WE);
    chk(writeEnableLatch, 1'b0);
    read_status_cmd(8'h00);
    // Status write with the latch clear must be refused
    M.csLow();
    M.xb(`SMPA_OP_WR_STAT, d);
    M.xb(8'h0C, d);
    M.csHigh();
    read_status_cmd(8'h00);
  endtask

  task automatic t_status();
    write_status_cmd(8'hFF);
    read_status_cmd(8'h8C);
    chk({protectPinEnable, blockProtectHi, blockProtectLo}, 3'h7);
    chk(writeEnableLatch, 1'b0);
    write_status_cmd(8'h80);
    M.writeProtect_n = 1'b0;
    write_status_cmd(8'h00);
    read_status_cmd(8'h80);
    wr(16'h0123, 8'h3C, 8'hC3, 1'b1);
    rd(16'h0123, 8'h3C, 8'hC3, -1);
    M.writeProtect_n = 1'b1;
    write_status_cmd(8'h00);
    read_status_cmd(8'h00);
    M.writeProtect_n = 1'b0;
    write_status_cmd(8'h08);
    read_status_cmd(8'h08);
    M.writeProtect_n = 1'b1;
    write_status_cmd(8'h00);
  endtask

  // Burst over the top address, pause mid-byte, write without latch
  task automatic t_burst();
    wr(16'hFFFF, 8'hA5, 8'h5A, 1'b1);
    chk(writeEnableLatch, 1'b0);
    rd(16'hF7FF, 8'hA5, 8'h5A, 3);
    wr(16'h07FF, 8'h00, 8'h00, 1'b0);
    rd(16'h07FF, 8'hA5, 8'h5A, -1);
  endtask

  // Burst from just below the quarter and half ranges and from the top address with all protected, then a reset
  task automatic t_protect();
    logic [15:0] a;
    for (int c = 1; c < 4; c++) begin
      a = (c == 1) ? 16'h05FF : (c == 2) ? 16'h03FF : 16'h07FF;
      write_status_cmd(8'h00);
      wr(a, 8'h11, 8'h22, 1'b1);
      write_status_cmd({4'h0, c[1:0], 2'b00});
      wr(a, 8'h40, 8'h50, 1'b1);
      rd(a, (c == 3) ? 8'h11 : 8'h40, 8'h22, -1);
    end
    @(posedge sys_clk);
    #1 rst_n = 1'b0;
    repeat (5) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    repeat (6) @(posedge sys_clk);
    read_status_cmd(8'h0C);
    chk({blockProtectHi, blockProtectLo}, 2'h3);
  endtask

  // Unknown opcodes keep the output floating and change nothing
  task automatic t_badop();
    smpa_byte_t ops [4];
    ops = '{8'h00, 8'hFF, 8'h07, 8'h86};
    foreach (ops[k]) begin
      M.csLow();
      M.xb(ops[k], d);
      M.xb(`SMPA_OP_RD_STAT, d);
      M.xb(8'h00, s);
      M.csHigh();
      chk(s, 8'hZZ);
    end
    chk(writeEnableLatch, 1'b0);
    read_status_cmd(8'h0C);
  endtask

  // Main sequence
  initial begin
    repeat (5) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    repeat (5) @(posedge sys_clk);
    t_latch();
    t_status();
    t_burst();
    t_protect();
    t_badop();
    test_done();
  end
endmodule
`default_nettype wire
